// >>> common/gpbc_pkg.sv
// Constants for the pin bank configuration registers
package gpbc_pkg;

    localparam int unsigned GPBC_DATA_W = 8;
    localparam int unsigned GPBC_BANK_W = 8;
    localparam int unsigned GPBC_BUF_W  = 8;

    // Configuration index values of the five registers
    localparam logic [7:0] GPBC_IDX_BANK3_DIRECTION = 8'h35;
    localparam logic [7:0] GPBC_IDX_BANK3_POLARITY  = 8'h36;
    localparam logic [7:0] GPBC_IDX_BANK4_DIRECTION = 8'h37;
    localparam logic [7:0] GPBC_IDX_BANK4_POLARITY  = 8'h38;
    localparam logic [7:0] GPBC_IDX_OUTPUT_BUFFER   = 8'h39;

    // Values after standby power-on reset
    localparam logic [7:0] GPBC_RST_BANK3_DIRECTION = 8'h00;
    localparam logic [7:0] GPBC_RST_BANK3_POLARITY  = 8'h00;
    localparam logic [7:0] GPBC_RST_BANK4_DIRECTION = 8'h00;
    localparam logic [7:0] GPBC_RST_BANK4_POLARITY  = 8'h80;
    localparam logic [7:0] GPBC_RST_OUTPUT_BUFFER   = 8'h00;
    localparam logic [7:0] GPBC_RST_READ_DATA       = 8'h00;

    // Field positions in the output buffer register
    localparam int unsigned GPBC_BUF_BANK1_LSB  = 0;
    localparam int unsigned GPBC_BUF_BANK1_W    = 6;
    localparam int unsigned GPBC_BUF_BANK2_PIN0 = 6;
    localparam int unsigned GPBC_BUF_WAKE_PIN   = 7;

    // Access to one register: configuration state and own index
    function automatic logic gpbc_hit(input logic       config_state,
                                      input logic [7:0] config_index,
                                      input logic [7:0] reg_index);
        gpbc_hit = config_state && (config_index == reg_index);
    endfunction : gpbc_hit

endpackage : gpbc_pkg

// >>> logic/gpbc_config_regs.sv
// Pin bank 3/4 direction, polarity and output buffer type registers
`timescale 1ns/1ps
module gpbc_config_regs import gpbc_pkg::*; #(
    parameter int unsigned BANK_W = GPBC_BANK_W,
    parameter int unsigned BUF_W  = GPBC_BUF_W
) (
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    // Configuration port side
    input  wire logic                   config_state_in,
    input  wire logic [7:0]             config_index_in,
    input  wire logic                   config_write_in,
    input  wire logic                   config_read_in,
    input  wire logic [GPBC_DATA_W-1:0] config_write_data_in,
    output logic      [GPBC_DATA_W-1:0] config_read_data_out,
    output logic                        config_read_valid_out,
    // Bank 3 pins
    input  wire logic [BANK_W-1:0]      bank3_data_in,
    input  wire logic [BANK_W-1:0]      bank3_pin_in,
    output logic      [BANK_W-1:0]      bank3_pin_out,
    output logic      [BANK_W-1:0]      bank3_pin_oe_out,
    output logic      [BANK_W-1:0]      bank3_value_out,
    // Bank 4 pins
    input  wire logic [BANK_W-1:0]      bank4_data_in,
    input  wire logic [BANK_W-1:0]      bank4_pin_in,
    output logic      [BANK_W-1:0]      bank4_pin_out,
    output logic      [BANK_W-1:0]      bank4_pin_oe_out,
    output logic      [BANK_W-1:0]      bank4_value_out,
    // Pins with selectable buffer type: bank1 pin2..7, bank2 pin0, wake
    input  wire logic [BUF_W-1:0]       buffered_drive_in,
    input  wire logic [BUF_W-1:0]       buffered_data_in,
    output logic      [BUF_W-1:0]       buffered_pin_out,
    output logic      [BUF_W-1:0]       buffered_pin_oe_out,
    // Register contents for the rest of the device
    output logic      [BUF_W-1:0]       output_buffer_type_out
);

    logic [BANK_W-1:0] pin_bank3_direction_reg;
    logic [BANK_W-1:0] pin_bank3_polarity_reg;
    logic [BANK_W-1:0] pin_bank4_direction_reg;
    logic [BANK_W-1:0] pin_bank4_polarity_reg;
    logic [BUF_W-1:0]  pin_output_buffer_type_reg;
    logic [GPBC_DATA_W-1:0] read_data_next;
    logic                   read_hit;

    logic hit_bank3_direction;
    logic hit_bank3_polarity;
    logic hit_bank4_direction;
    logic hit_bank4_polarity;
    logic hit_output_buffer;

    // Decode: outside the configuration state every index misses
    always_comb begin
        hit_bank3_direction = gpbc_hit(config_state_in, config_index_in, GPBC_IDX_BANK3_DIRECTION);
        hit_bank3_polarity  = gpbc_hit(config_state_in, config_index_in, GPBC_IDX_BANK3_POLARITY);
        hit_bank4_direction = gpbc_hit(config_state_in, config_index_in, GPBC_IDX_BANK4_DIRECTION);
        hit_bank4_polarity  = gpbc_hit(config_state_in, config_index_in, GPBC_IDX_BANK4_POLARITY);
        hit_output_buffer   = gpbc_hit(config_state_in, config_index_in, GPBC_IDX_OUTPUT_BUFFER);
    end

    // Bank 3 direction
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_bank3_direction_reg <= GPBC_RST_BANK3_DIRECTION;
        end else if (config_write_in && hit_bank3_direction) begin
            pin_bank3_direction_reg <= config_write_data_in[BANK_W-1:0];
        end
    end

    // Bank 3 polarity
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_bank3_polarity_reg <= GPBC_RST_BANK3_POLARITY;
        end else if (config_write_in && hit_bank3_polarity) begin
            pin_bank3_polarity_reg <= config_write_data_in[BANK_W-1:0];
        end
    end

    // Bank 4 direction
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_bank4_direction_reg <= GPBC_RST_BANK4_DIRECTION;
        end else if (config_write_in && hit_bank4_direction) begin
            pin_bank4_direction_reg <= config_write_data_in[BANK_W-1:0];
        end
    end

    // Bank 4 polarity; top pin comes out of reset inverted
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_bank4_polarity_reg <= GPBC_RST_BANK4_POLARITY;
        end else if (config_write_in && hit_bank4_polarity) begin
            pin_bank4_polarity_reg <= config_write_data_in[BANK_W-1:0];
        end
    end

    // Output buffer type
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_output_buffer_type_reg <= GPBC_RST_OUTPUT_BUFFER;
        end else if (config_write_in && hit_output_buffer) begin
            pin_output_buffer_type_reg <= config_write_data_in[BUF_W-1:0];
        end
    end

    // Read mux; a miss returns zero so other register blocks can be OR-ed in
    always_comb begin
        read_data_next = GPBC_RST_READ_DATA;
        read_hit       = 1'b1;
        case (1'b1)
            hit_bank3_direction: read_data_next = GPBC_DATA_W'(pin_bank3_direction_reg);
            hit_bank3_polarity:  read_data_next = GPBC_DATA_W'(pin_bank3_polarity_reg);
            hit_bank4_direction: read_data_next = GPBC_DATA_W'(pin_bank4_direction_reg);
            hit_bank4_polarity:  read_data_next = GPBC_DATA_W'(pin_bank4_polarity_reg);
            hit_output_buffer:   read_data_next = GPBC_DATA_W'(pin_output_buffer_type_reg);
            default:             read_hit       = 1'b0;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            config_read_data_out <= GPBC_RST_READ_DATA;
        end else if (config_read_in) begin
            config_read_data_out <= read_data_next;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            config_read_valid_out <= 1'b0;
        end else begin
            config_read_valid_out <= config_read_in && read_hit;
        end
    end

    // Bank 3 pin stage
    gpbc_pin_bank #(
        .WIDTH(BANK_W)
    ) u_bank3 (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .direction_in (pin_bank3_direction_reg),
        .polarity_in  (pin_bank3_polarity_reg),
        .pin_data_in  (bank3_data_in),
        .pin_in       (bank3_pin_in),
        .pin_out      (bank3_pin_out),
        .pin_oe_out   (bank3_pin_oe_out),
        .pin_value_out(bank3_value_out)
    );

    // Bank 4 pin stage
    gpbc_pin_bank #(
        .WIDTH(BANK_W)
    ) u_bank4 (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .direction_in (pin_bank4_direction_reg),
        .polarity_in  (pin_bank4_polarity_reg),
        .pin_data_in  (bank4_data_in),
        .pin_in       (bank4_pin_in),
        .pin_out      (bank4_pin_out),
        .pin_oe_out   (bank4_pin_oe_out),
        .pin_value_out(bank4_value_out)
    );

    // Open drain never drives high: only the low level is driven
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            buffered_pin_out <= '0;
        end else begin
            buffered_pin_out <= buffered_data_in & ~pin_output_buffer_type_reg;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            buffered_pin_oe_out <= '0;
        end else begin
            buffered_pin_oe_out <= buffered_drive_in
                                 & ~(pin_output_buffer_type_reg & buffered_data_in);
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            output_buffer_type_out <= GPBC_RST_OUTPUT_BUFFER;
        end else begin
            output_buffer_type_out <= pin_output_buffer_type_reg;
        end
    end

endmodule : gpbc_config_regs

// >>> logic/gpbc_pin_bank.sv
// One bank of general purpose pins: direction and polarity applied
`timescale 1ns/1ps
module gpbc_pin_bank import gpbc_pkg::*; #(
    parameter int unsigned WIDTH = GPBC_BANK_W
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] direction_in,
    input  wire logic [WIDTH-1:0] polarity_in,
    input  wire logic [WIDTH-1:0] pin_data_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_out,
    output logic      [WIDTH-1:0] pin_value_out
);

    // Drive path: data register value through the polarity stage
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_out <= '0;
        end else begin
            pin_out <= pin_data_in ^ polarity_in;
        end
    end

    // Direction bit one enables the driver
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_oe_out <= '0;
        end else begin
            pin_oe_out <= direction_in;
        end
    end

    // Sample path: pin level through the same polarity stage
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_value_out <= '0;
        end else begin
            pin_value_out <= pin_in ^ polarity_in;
        end
    end

endmodule : gpbc_pin_bank

// >>> testbench/gpbc_config_regs_props.sv
// Checker for the pin bank configuration registers
`timescale 1ns/1ps
module gpbc_config_regs_chk import gpbc_pkg::*; #(
    parameter int unsigned BANK_W = GPBC_BANK_W,
    parameter int unsigned BUF_W  = GPBC_BUF_W
) (
    input wire logic                   clk_in,
    input wire logic                   reset_in,
    input wire logic                   config_state_in,
    input wire logic [7:0]             config_index_in,
    input wire logic                   config_write_in,
    input wire logic                   config_read_in,
    input wire logic [GPBC_DATA_W-1:0] config_write_data_in,
    input wire logic [GPBC_DATA_W-1:0] config_read_data_out,
    input wire logic                   config_read_valid_out,
    input wire logic [BANK_W-1:0]      bank3_pin_oe_out,
    input wire logic [BANK_W-1:0]      bank4_pin_oe_out,
    input wire logic [BUF_W-1:0]       buffered_drive_in,
    input wire logic [BUF_W-1:0]       buffered_data_in,
    input wire logic [BUF_W-1:0]       buffered_pin_out,
    input wire logic [BUF_W-1:0]       buffered_pin_oe_out,
    input wire logic [BUF_W-1:0]       output_buffer_type_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire hit = config_state_in && config_index_in >= 8'h35 && config_index_in <= 8'h39;
    wire rd3 = config_read_in && config_state_in && config_index_in == 8'h35;
    rd_hit_a: assert property (config_read_in && hit |=> config_read_valid_out)
        else $error("read hit gave no valid");
    rd_miss_a: assert property (config_read_in && !hit |=> !config_read_valid_out && config_read_data_out == 8'h00)
        else $error("refused read answered");
    rd_hold_a: assert property (!config_read_in |=> $stable(config_read_data_out))
        else $error("read data moved without strobe");
    rd_dir3_a: assert property (rd3 |=> config_read_data_out == bank3_pin_oe_out)
        else $error("bank3 direction readback differs");
    rd_dir4_a: assert property (config_read_in && config_state_in && config_index_in == 8'h37
        |=> config_read_data_out == bank4_pin_oe_out) else $error("bank4 direction readback differs");
    rd_buf_a: assert property (config_read_in && config_state_in && config_index_in == 8'h39
        |=> config_read_data_out == output_buffer_type_out) else $error("buffer type readback differs");
    wr_dir3_a: assert property (config_write_in && config_state_in && config_index_in == 8'h35
        |=> ##1 bank3_pin_oe_out == $past(config_write_data_in, 2)) else $error("bank3 direction not applied");
    buf_pp_a: assert property (!$past(reset_in) |->
        buffered_pin_out == ($past(buffered_data_in) & ~output_buffer_type_out)) else $error("buffer level wrong");
    buf_od_a: assert property (!$past(reset_in) |-> buffered_pin_oe_out ==
        ($past(buffered_drive_in) & ~(output_buffer_type_out & $past(buffered_data_in)))) else $error("buffer enable wrong");
    cover property (config_write_in && config_state_in && config_index_in == 8'h39);
    cover property (config_read_in && !hit);
    cover property (buffered_pin_oe_out != 8'h00 && output_buffer_type_out != 8'h00);
endmodule : gpbc_config_regs_chk

bind gpbc_config_regs gpbc_config_regs_chk #(.BANK_W(BANK_W), .BUF_W(BUF_W)) i_gpbc_config_regs_chk (
    .clk_in(clk_in), .reset_in(reset_in), .config_state_in(config_state_in), .config_index_in(config_index_in),
    .config_write_in(config_write_in), .config_read_in(config_read_in), .config_write_data_in(config_write_data_in),
    .config_read_data_out(config_read_data_out), .config_read_valid_out(config_read_valid_out),
    .bank3_pin_oe_out(bank3_pin_oe_out), .bank4_pin_oe_out(bank4_pin_oe_out), .buffered_drive_in(buffered_drive_in),
    .buffered_data_in(buffered_data_in), .buffered_pin_out(buffered_pin_out),
    .buffered_pin_oe_out(buffered_pin_oe_out), .output_buffer_type_out(output_buffer_type_out));

// >>> testbench/gpbc_pin_partner.sv
// External circuitry on one bank of general purpose pins
`timescale 1ns/1ps
module gpbc_pin_partner (
    input  wire logic [7:0] pin_out_in,
    input  wire logic [7:0] pin_oe_in,
    input  wire logic [7:0] ext_level_in,
    output logic      [7:0] pin_level_out
);
    // Released pins follow the outside source, never the last driven level
    assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
endmodule : gpbc_pin_partner

// >>> testbench/test_gpio_bank_pin_config.sv
// Register and pin path tests for the pin bank configuration block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_gpio_bank_pin_config import gpbc_pkg::*; ;
    logic clk_in = 0, reset_in = 1, st, wr, rd, rvalid;
    logic [7:0] idx, wd, rdat, d3, d4, e3, e4, p3, p4, drv, bd, bpo, boe, bto, o3, oe3, v3, o4, oe4, v4;
    int num_errors = 0, compares = 0, cycles = 0;
    logic [7:0] ix[5] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39};
    logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    logic [7:0] wv[5] = '{8'hA5, 8'h0F, 8'h5A, 8'hF0, 8'hF0};
    gpbc_config_regs i_gpbc_config_regs (.clk_in(clk_in), .reset_in(reset_in), .config_state_in(st),
        .config_index_in(idx), .config_write_in(wr), .config_read_in(rd), .config_write_data_in(wd),
        .config_read_data_out(rdat), .config_read_valid_out(rvalid), .bank3_data_in(d3), .bank3_pin_in(p3),
        .bank3_pin_out(o3), .bank3_pin_oe_out(oe3), .bank3_value_out(v3), .bank4_data_in(d4), .bank4_pin_in(p4),
        .bank4_pin_out(o4), .bank4_pin_oe_out(oe4), .bank4_value_out(v4), .buffered_drive_in(drv),
        .buffered_data_in(bd), .buffered_pin_out(bpo), .buffered_pin_oe_out(boe), .output_buffer_type_out(bto));
    gpbc_pin_partner i_gpbc_pin_partner3 (.pin_out_in(o3), .pin_oe_in(oe3), .ext_level_in(e3), .pin_level_out(p3));
    gpbc_pin_partner i_gpbc_pin_partner4 (.pin_out_in(o4), .pin_oe_in(oe4), .ext_level_in(e4), .pin_level_out(p4));
    always #2.5 clk_in = ~clk_in;
    task automatic complete_run();
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // Ceiling well above the roughly 70 cycles the sequence needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 3000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic cyc(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc
    task automatic wreg(logic s, logic [7:0] i, logic [7:0] d);
        st = s; idx = i; wd = d; wr = 1;
        cyc(1);
        wr = 0; st = 1;
        // Idle edge so the next call never reassigns a strobe in this time step
        cyc(1);
    endtask : wreg
    task automatic rreg(logic s, logic [7:0] i, logic [7:0] e, logic v);
        st = s; idx = i; rd = 1;
        cyc(1);
        rd = 0; st = 1;
        `CHK("read data", e, rdat)
        `CHK("read valid", v, rvalid)
        cyc(1);
    endtask : rreg
    initial begin
        st = 1; idx = 0; wd = 0; wr = 0; rd = 0; d3 = 8'h33; d4 = 8'hC3; e3 = 8'h55; e4 = 8'h0F;
        drv = 8'hFF; bd = 8'hAA;
        cyc(10);
        reset_in = 0;
        cyc(1);
        for (int k = 0; k < 5; k++) rreg(1, ix[k], rv[k], 1);
        `CHK("bank4 value", e4 ^ 8'h80, v4)
        wreg(0, 8'h36, 8'hFF);
        wreg(1, 8'h34, 8'hFF);
        wreg(1, 8'h3A, 8'hFF);
        rreg(1, 8'h36, 8'h00, 1);
        rreg(1, 8'h3A, 8'h00, 0);
        rreg(0, 8'h35, 8'h00, 0);
        wreg(1, 8'h36, 8'h0F);
        wreg(1, 8'h38, 8'hF0);
        cyc(2);
        `CHK("bank3 drive", d3 ^ 8'h0F, o3)
        `CHK("bank3 value", e3 ^ 8'h0F, v3)
        `CHK("bank4 drive", d4 ^ 8'hF0, o4)
        `CHK("bank4 value", e4 ^ 8'hF0, v4)
        wreg(1, 8'h35, 8'hA5);
        wreg(1, 8'h37, 8'h5A);
        wreg(1, 8'h39, 8'hF0);
        cyc(3);
        `CHK("bank3 enable", 8'hA5, oe3)
        `CHK("bank4 enable", 8'h5A, oe4)
        `CHK("bank3 looped", ((8'hA5 & d3 ^ 8'hA5 & 8'h0F) | (8'h5A & e3)) ^ 8'h0F, v3)
        `CHK("buffer level", 8'h0A, bpo)
        `CHK("buffer enable", 8'h5F, boe)
        `CHK("buffer type", 8'hF0, bto)
        for (int k = 0; k < 5; k++) rreg(1, ix[k], wv[k], 1);
        reset_in = 1;
        cyc(2);
        reset_in = 0;
        cyc(1);
        `CHK("bank3 enable", 8'h00, oe3)
        for (int k = 0; k < 5; k++) rreg(1, ix[k], rv[k], 1);
        complete_run();
    end
endmodule : test_gpio_bank_pin_config
